// ---- logic/cable_diag_pkg.sv ----
// shared constants and carrier types for the cable diagnostic registers
package cable_diag_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] REFL_CTRL_OFF = 5'h16;
  localparam logic [ADDR_W-1:0] PEAK_OFF      = 5'h18;
  localparam logic [ADDR_W-1:0] THR_OFF       = 5'h19;
  localparam logic [ADDR_W-1:0] VAR_CTRL_OFF  = 5'h1a;
  localparam logic [ADDR_W-1:0] VAR_DATA_OFF  = 5'h1b;

  // reflect control fields
  localparam int SEND_BIT     = 11;
  localparam int MIN_MODE_BIT = 7;
  localparam int THR_LSB      = 0;
  localparam int SAMPLE_W     = 6;
  localparam logic [SAMPLE_W-1:0] THRESHOLD_RST = 6'h20;

  // result fields
  localparam int TIME_W         = 8;
  localparam int PEAK_TIME_LSB  = 0;
  localparam int PEAK_VALUE_LSB = 8;
  localparam int THR_TIME_LSB   = 0;
  localparam int MET_BIT        = 8;

  // variance control fields
  localparam int READY_BIT  = 15;
  localparam int FREEZE_BIT = 3;
  localparam int TIMER_LSB  = 1;
  localparam int TIMER_W    = 2;
  localparam int ENABLE_BIT = 0;
  localparam logic [TIMER_W-1:0] TIMER_RST = 2'h0;
  localparam int SUM_W      = 32;
  localparam int HALF_W     = 16;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS       = 8;
  localparam int TICK_DIV      = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_CW       = 1;
  localparam int UNIT_PS       = 1048576000;
  localparam int UNIT_TICKS    = UNIT_PS / (TICK_NS * 1000);
  localparam int UNIT_CW       = 17;
  localparam int UNITS_W       = 4;
  localparam int SEND_MAX_CYC  = 600;

  typedef struct packed {
    logic [TIME_W-1:0] start;
    logic [TIME_W-1:0] stop;
  } window_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] peak_value;
    logic [TIME_W-1:0]   peak_time;
    logic                thr_met;
    logic [TIME_W-1:0]   thr_time;
  } reflect_result_t;

endpackage

// ---- logic/reflect_window_detector.sv ----
// peak and threshold capture over one reflectometry sample window
`timescale 1ns/10ps
module reflect_window_detector (
  input  wire logic                                  core_clk_in,
  input  wire logic                                  srst_in,
  input  wire logic                                  tick_in,
  input  wire logic                                  start_in,
  input  wire logic                                  min_mode_in,
  input  wire logic [cable_diag_pkg::SAMPLE_W-1:0]   threshold_in,
  input  wire cable_diag_pkg::window_t               window_in,
  input  wire logic [cable_diag_pkg::SAMPLE_W-1:0]   sample_in,
  output logic                                       done_out,
  output cable_diag_pkg::reflect_result_t            result_out
);

  typedef enum logic {det_idle, det_capture} det_state_t;

  det_state_t                              state, next_state;
  logic [cable_diag_pkg::TIME_W-1:0]       time_cnt, next_time_cnt;
  logic                                    have_peak, next_have_peak;
  logic                                    min_mode, next_min_mode;
  logic [cable_diag_pkg::SAMPLE_W-1:0]     thr, next_thr;
  cable_diag_pkg::window_t                 win, next_win;
  cable_diag_pkg::reflect_result_t         work, next_work;
  cable_diag_pkg::reflect_result_t         next_result;
  logic                                    next_done;
  logic                                    in_win;
  logic                                    better;
  logic                                    meets;

  always_comb begin
    next_state     = state;
    next_time_cnt  = time_cnt;
    next_have_peak = have_peak;
    next_min_mode  = min_mode;
    next_thr       = thr;
    next_win       = win;
    next_work      = work;
    next_result    = result_out;
    next_done      = 1'b0;
    in_win = (time_cnt >= win.start) && (time_cnt <= win.stop);
    // strict compare keeps the time of the first equal extreme
    better = !have_peak ||
             (min_mode ? (sample_in < work.peak_value)
                       : (sample_in > work.peak_value)); // RULE_02 RULE_03
    meets = min_mode ? (sample_in < thr) : (sample_in > thr);
    unique case (state)
      det_idle: begin
        if (start_in) begin
          next_state     = det_capture;
          next_time_cnt  = '0;
          next_have_peak = 1'b0;
          next_min_mode  = min_mode_in; // RULE_19
          next_thr       = threshold_in;
          next_win       = window_in;
          next_work      = '0;
        end
      end
      det_capture: begin
        if (tick_in) begin
          // one tick is one 8 ns sample step
          if (in_win) begin // RULE_18
            if (better) begin
              next_have_peak       = 1'b1;
              next_work.peak_value = sample_in; // RULE_02
              next_work.peak_time  = time_cnt; // RULE_03
            end
            if (meets && !work.thr_met) begin
              next_work.thr_met  = 1'b1; // RULE_05
              next_work.thr_time = time_cnt; // RULE_06
            end
          end
          if (time_cnt >= win.stop) begin
            next_state  = det_idle;
            next_result = next_work; // RULE_01
            next_done   = 1'b1;
          end else begin
            next_time_cnt = time_cnt + 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state      <= det_idle;
      time_cnt   <= '0;
      have_peak  <= 1'b0;
      min_mode   <= 1'b0;
      thr        <= cable_diag_pkg::THRESHOLD_RST;
      win        <= '0;
      work       <= '0;
      result_out <= '0;
      done_out   <= 1'b0;
    end else begin
      state      <= next_state;
      time_cnt   <= next_time_cnt;
      have_peak  <= next_have_peak;
      min_mode   <= next_min_mode;
      thr        <= next_thr;
      win        <= next_win;
      work       <= next_work;
      result_out <= next_result;
      done_out   <= next_done;
    end
  end

endmodule

// ---- logic/cable_diag_results_variance.sv ----
// reflectometry result and signal variance register bank
//
// What this block does
// [RULE_01] results valid once send bit clears again
// [RULE_02] peak field holds max, or min in minimum mode
// [RULE_03] peak time marks first occurrence of peak
// [RULE_04] reserved bits ignore writes, read zero
// [RULE_05] threshold flag set when any sample met it
// [RULE_06] threshold time marks first meeting sample
// [RULE_07] ready flag clears after two data reads
// [RULE_08] freeze holds data, clears after two reads
// [RULE_09] timer code selects 2, 4, 6, 8 units
// [RULE_10] new timer value restarts the computation
// [RULE_11] data loads only at period end, unfrozen
// [RULE_12] one unit is 2^17 ticks of 8 ns
// [RULE_13] enable bit gates computation, resets off
// [RULE_14] first read low half, second high half
// [RULE_15] host sets freeze after seeing ready
// [RULE_16] data valid only while ready is set
// [RULE_17] send bit self-clears when capture completes
// [RULE_18] window and result times in 8 ns steps
// [RULE_19] minimum mode selects negative peak detection
// [RULE_20] half toggle resets when freeze newly set
// [RULE_21] disabled engine stays idle, no ready
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module cable_diag_results_variance #(
  parameter int unsigned UNIT_TICKS = cable_diag_pkg::UNIT_TICKS
) (
  input  wire logic                                core_clk_in,
  input  wire logic                                srst_in,
  input  wire logic [cable_diag_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [cable_diag_pkg::DATA_W-1:0]   reg_wdata_in,
  input  wire logic                                reg_wr_in,
  input  wire logic                                reg_rd_in,
  output logic      [cable_diag_pkg::DATA_W-1:0]   reg_rdata_out,
  input  wire cable_diag_pkg::window_t             window_in,
  input  wire logic [cable_diag_pkg::SAMPLE_W-1:0] sample_value_in,
  input  wire logic [cable_diag_pkg::HALF_W-1:0]   variance_term_in,
  input  wire logic                                variance_term_valid_in,
  output logic                                     pulse_send_out
);

  function automatic logic hit(input logic [cable_diag_pkg::ADDR_W-1:0] a,
                               input logic [cable_diag_pkg::ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode and 8 ns tick

  logic                                  wr_refl;
  logic                                  wr_var;
  logic                                  rd_data;
  logic [cable_diag_pkg::TICK_CW-1:0]    tick_cnt, next_tick_cnt;
  logic                                  tick;

  assign wr_refl = reg_wr_in && hit(reg_addr_in, cable_diag_pkg::REFL_CTRL_OFF);
  assign wr_var  = reg_wr_in && hit(reg_addr_in, cable_diag_pkg::VAR_CTRL_OFF);
  assign rd_data = reg_rd_in && hit(reg_addr_in, cable_diag_pkg::VAR_DATA_OFF);

  always_comb begin
    tick = (tick_cnt == cable_diag_pkg::TICK_CW'(cable_diag_pkg::TICK_DIV - 1));
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reflectometry control and capture

  logic                                  min_mode, next_min_mode;
  logic [cable_diag_pkg::SAMPLE_W-1:0]   threshold, next_threshold;
  logic                                  next_send;
  logic                                  det_start;
  logic                                  det_done;
  cable_diag_pkg::reflect_result_t       result;

  assign det_start = wr_refl && !pulse_send_out &&
                     reg_wdata_in[cable_diag_pkg::SEND_BIT];

  always_comb begin
    next_min_mode  = min_mode;
    next_threshold = threshold;
    next_send      = pulse_send_out;
    if (wr_refl) begin
      next_min_mode  = reg_wdata_in[cable_diag_pkg::MIN_MODE_BIT]; // RULE_19
      next_threshold = reg_wdata_in[cable_diag_pkg::THR_LSB +:
                                    cable_diag_pkg::SAMPLE_W];
    end
    if (det_start) begin
      next_send = 1'b1;
    end else if (det_done) begin
      next_send = 1'b0; // RULE_17
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      min_mode       <= 1'b0;
      threshold      <= cable_diag_pkg::THRESHOLD_RST;
      pulse_send_out <= 1'b0;
    end else begin
      min_mode       <= next_min_mode;
      threshold      <= next_threshold;
      pulse_send_out <= next_send;
    end
  end

  reflect_window_detector u_detector (
    .core_clk_in  (core_clk_in),
    .srst_in      (srst_in),
    .tick_in      (tick),
    .start_in     (det_start),
    .min_mode_in  (next_min_mode),
    .threshold_in (next_threshold),
    .window_in    (window_in),
    .sample_in    (sample_value_in),
    .done_out     (det_done),
    .result_out   (result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // variance control bits

  logic                                  enable, next_enable;
  logic                                  freeze, next_freeze;
  logic [cable_diag_pkg::TIMER_W-1:0]    timer, next_timer;
  logic                                  ready, next_ready;
  logic                                  half_sel, next_half_sel;
  logic                                  freeze_rise;
  logic                                  second_read;
  logic                                  timer_restart;
  logic                                  period_end;
  logic                                  load_sum;
  logic [cable_diag_pkg::TIMER_W-1:0]    wr_timer;

  assign wr_timer = reg_wdata_in[cable_diag_pkg::TIMER_LSB +:
                                 cable_diag_pkg::TIMER_W];
  assign timer_restart = wr_var && (wr_timer != timer); // RULE_10
  assign freeze_rise = wr_var && !freeze &&
                       reg_wdata_in[cable_diag_pkg::FREEZE_BIT];
  assign second_read = rd_data && half_sel;
  assign load_sum    = period_end && !freeze; // RULE_11

  always_comb begin
    next_enable   = enable;
    next_freeze   = freeze;
    next_timer    = timer;
    next_half_sel = half_sel;
    if (wr_var) begin
      next_enable = reg_wdata_in[cable_diag_pkg::ENABLE_BIT]; // RULE_13
      next_freeze = reg_wdata_in[cable_diag_pkg::FREEZE_BIT]; // RULE_08
      next_timer  = wr_timer; // RULE_09
    end else if (second_read) begin
      next_freeze = 1'b0; // RULE_08
    end
    if (freeze_rise) begin
      next_half_sel = 1'b0; // RULE_20
    end else if (rd_data) begin
      next_half_sel = !half_sel; // RULE_14
    end
    // a fresh sum beats the clearing read in the same cycle
    next_ready = load_sum || (ready && !second_read); // RULE_07 RULE_16
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      enable   <= 1'b0;
      freeze   <= 1'b0;
      timer    <= cable_diag_pkg::TIMER_RST;
      ready    <= 1'b0;
      half_sel <= 1'b0;
    end else begin
      enable   <= next_enable;
      freeze   <= next_freeze;
      timer    <= next_timer;
      ready    <= next_ready;
      half_sel <= next_half_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // variance timer and accumulator

  logic [cable_diag_pkg::UNIT_CW-1:0]    unit_cnt, next_unit_cnt;
  logic [cable_diag_pkg::UNITS_W-1:0]    unit_num, next_unit_num;
  logic [cable_diag_pkg::UNITS_W-1:0]    period_units;
  logic [cable_diag_pkg::SUM_W-1:0]      acc, next_acc;
  logic [cable_diag_pkg::SUM_W-1:0]      var_data, next_var_data;
  logic [cable_diag_pkg::SUM_W-1:0]      term;
  logic                                  unit_end;

  // two nominal milliseconds per timer code step
  assign period_units = {3'({1'b0, timer} + 3'h1), 1'b0}; // RULE_09
  assign unit_end = tick &&
    (unit_cnt == cable_diag_pkg::UNIT_CW'(UNIT_TICKS - 1)); // RULE_12
  assign period_end = enable && !timer_restart && unit_end &&
                      (unit_num == period_units - 4'h1); // RULE_21
  assign term = variance_term_valid_in ?
                {{(cable_diag_pkg::SUM_W - cable_diag_pkg::HALF_W){1'b0}},
                 variance_term_in} : '0;

  always_comb begin
    next_unit_cnt = unit_cnt;
    next_unit_num = unit_num;
    next_acc      = acc;
    next_var_data = var_data;
    if (!enable || timer_restart) begin
      next_unit_cnt = '0; // RULE_10 RULE_21
      next_unit_num = '0;
      next_acc      = '0;
    end else begin
      next_acc = acc + term;
      if (unit_end) begin
        next_unit_cnt = '0;
        next_unit_num = unit_num + 4'h1;
      end else if (tick) begin
        next_unit_cnt = unit_cnt + 1'b1;
      end
      if (period_end) begin
        next_unit_num = '0;
        next_acc      = term;
      end
    end
    if (load_sum) begin
      next_var_data = acc; // RULE_11
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      unit_cnt <= '0;
      unit_num <= '0;
      acc      <= '0;
      var_data <= '0;
    end else begin
      unit_cnt <= next_unit_cnt;
      unit_num <= next_unit_num;
      acc      <= next_acc;
      var_data <= next_var_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  logic [cable_diag_pkg::DATA_W-1:0]     next_rdata;

  always_comb begin
    next_rdata = '0; // RULE_04
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        cable_diag_pkg::REFL_CTRL_OFF: begin
          next_rdata[cable_diag_pkg::SEND_BIT]     = pulse_send_out;
          next_rdata[cable_diag_pkg::MIN_MODE_BIT] = min_mode;
          next_rdata[cable_diag_pkg::THR_LSB +:
                     cable_diag_pkg::SAMPLE_W]     = threshold;
        end
        cable_diag_pkg::PEAK_OFF: begin
          next_rdata[cable_diag_pkg::PEAK_VALUE_LSB +:
                     cable_diag_pkg::SAMPLE_W] = result.peak_value; // RULE_02
          next_rdata[cable_diag_pkg::PEAK_TIME_LSB +:
                     cable_diag_pkg::TIME_W] = result.peak_time; // RULE_03
        end
        cable_diag_pkg::THR_OFF: begin
          next_rdata[cable_diag_pkg::MET_BIT] = result.thr_met; // RULE_05
          next_rdata[cable_diag_pkg::THR_TIME_LSB +:
                     cable_diag_pkg::TIME_W] = result.thr_time; // RULE_06
        end
        cable_diag_pkg::VAR_CTRL_OFF: begin
          next_rdata[cable_diag_pkg::READY_BIT]  = ready; // RULE_07
          next_rdata[cable_diag_pkg::FREEZE_BIT] = freeze;
          next_rdata[cable_diag_pkg::TIMER_LSB +:
                     cable_diag_pkg::TIMER_W]    = timer;
          next_rdata[cable_diag_pkg::ENABLE_BIT] = enable;
        end
        cable_diag_pkg::VAR_DATA_OFF: begin
          next_rdata = half_sel ?
            var_data[cable_diag_pkg::SUM_W-1:cable_diag_pkg::HALF_W] :
            var_data[cable_diag_pkg::HALF_W-1:0]; // RULE_14
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [cable_diag_pkg::HALF_W-1:0] var_lo;
  logic [cable_diag_pkg::HALF_W-1:0] var_hi;
  assign var_lo = var_data[cable_diag_pkg::HALF_W-1:0];
  assign var_hi = var_data[cable_diag_pkg::SUM_W-1:cable_diag_pkg::HALF_W];

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence low_read_s;
    rd_data && !half_sel;
  endsequence

  sequence high_read_s;
    rd_data && half_sel;
  endsequence

  low_half_a: assert property (low_read_s |=> // RULE_14
    reg_rdata_out == $past(var_lo))
    else $error("first data read did not return low half");

  high_half_a: assert property (high_read_s |=> // RULE_14
    reg_rdata_out == $past(var_hi))
    else $error("second data read did not return high half");

  ready_clear_a: assert property ((high_read_s and !load_sum) |=> // RULE_07
    !ready)
    else $error("ready not cleared after two data reads");

  freeze_clear_a: assert property ((high_read_s and freeze) |=> // RULE_08
    !freeze)
    else $error("freeze not cleared after two data reads");

  freeze_hold_a: assert property (freeze |=> $stable(var_data)) // RULE_11
    else $error("data changed while frozen");

  load_end_a: assert property (!$stable(var_data) |-> // RULE_11
    $past(period_end) && ready)
    else $error("data loaded outside period end");

  idle_off_a: assert property (!enable |=> // RULE_21
    unit_cnt == '0 && acc == '0 && !period_end)
    else $error("variance engine active while disabled");

  restart_a: assert property (enable && timer_restart |=> // RULE_10
    unit_cnt == '0 && unit_num == '0)
    else $error("timer write did not restart computation");

  rsvd_ctrl_a: assert property ( // RULE_04
    reg_rd_in && hit(reg_addr_in, cable_diag_pkg::VAR_CTRL_OFF) |=>
    reg_rdata_out[14:4] == 11'h000)
    else $error("reserved control bits read nonzero");

  send_clear_a: assert property ($rose(pulse_send_out) |-> // RULE_17
    ##[1:600] !pulse_send_out)
    else $error("send bit did not self-clear");

  result_valid_a: assert property (!$stable(result) |-> // RULE_01
    det_done && pulse_send_out ##1 !pulse_send_out)
    else $error("results changed without the send bit clearing");

  half_reset_a: assert property (freeze_rise |=> !half_sel) // RULE_20
    else $error("half toggle not reset when freeze set");

endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the cable diagnostic register bank
`timescale 1ns/10ps
module tb_top;
  logic                    core_clk_in;
  logic                    srst_in;
  logic [4:0]              reg_addr_in;
  logic [15:0]             reg_wdata_in;
  logic                    reg_wr_in;
  logic                    reg_rd_in;
  logic [15:0]             reg_rdata_out;
  cable_diag_pkg::window_t window_in;
  logic [5:0]              sample_value_in;
  logic [15:0]             variance_term_in;
  logic                    variance_term_valid_in;
  logic                    pulse_send_out;
  int                      failures = 0;
  int                      check_count = 0;
  int                      cycles = 0;
  int                      n;
  int                      t0;
  int                      codes [4] = '{1, 2, 3, 0};
  logic [4:0]              addrs [6] = '{5'h18, 5'h19, 5'h1a, 5'h1b,
                                         5'h00, 5'h17};
  logic [15:0]             d;
  logic [15:0]             pk;
  logic [15:0]             th;

  cable_diag_results_variance #(.UNIT_TICKS(8)) u_cable_diag_results_variance (
    .core_clk_in            (core_clk_in),
    .srst_in                (srst_in),
    .reg_addr_in            (reg_addr_in),
    .reg_wdata_in           (reg_wdata_in),
    .reg_wr_in              (reg_wr_in),
    .reg_rd_in              (reg_rd_in),
    .reg_rdata_out          (reg_rdata_out),
    .window_in              (window_in),
    .sample_value_in        (sample_value_in),
    .variance_term_in       (variance_term_in),
    .variance_term_valid_in (variance_term_valid_in),
    .pulse_send_out         (pulse_send_out)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  // hang guard
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask

  // one pulse request; sample switches from s0 to s1 mid-window
  task automatic capture(input logic [15:0] ctl, input logic [5:0] s0,
                         input logic [5:0] s1);
    sample_value_in <= s0;
    wr(5'h16, ctl);
    #1 check(16'(pulse_send_out), 16'h0001);
    rd(5'h16, d);
    check(d, ctl);
    repeat (40) @(posedge core_clk_in);
    sample_value_in <= s1;
    n = 0;
    while (pulse_send_out !== 1'b0 && n < 400) begin
      @(posedge core_clk_in);
      #1;
      n = n + 1;
    end
    check(16'(n < 400), 16'h0001);
    rd(5'h16, d);
    check(d, ctl & 16'hf7ff);
    rd(5'h18, pk);
    rd(5'h19, th);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst_in = 1'b1;
    reg_addr_in = 5'h00;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    window_in = '{start: 8'h03, stop: 8'h28};
    sample_value_in = 6'h00;
    variance_term_in = 16'hffff;
    variance_term_valid_in = 1'b1;
    repeat (16) @(posedge core_clk_in);
    srst_in <= 1'b0;
    // reset values, read-only and reserved places, idle engine
    repeat (100) @(posedge core_clk_in);
    foreach (addrs[i]) begin
      wr(addrs[i], 16'hffff);
      rd(addrs[i], d);
      check(d, (i == 2) ? 16'h000f : 16'h0000);
    end
    wr(5'h1a, 16'hfff0);
    rd(5'h1a, d);
    check(d, 16'h0000);
    $display("test registers done");
    capture(16'h0820, 6'h28, 6'h28);
    check(pk, 16'h2803);
    check(th, 16'h0103);
    capture(16'h0820, 6'h28, 6'h38);
    check({8'h00, pk[15:8]}, 16'h0038);
    check(th, 16'h0103);
    capture(16'h08a0, 6'h28, 6'h18);
    check({8'h00, pk[15:8]}, 16'h0018);
    check({8'h00, th[15:8]}, 16'h0001);
    capture(16'h0890, 6'h28, 6'h28);
    check(pk, 16'h2803);
    check({8'h00, th[15:8]}, 16'h0000);
    $display("test capture done");
    // variance: 32 terms of 0xffff per 2-unit period
    wr(5'h1a, 16'h0001);
    n = 0;
    do begin
      rd(5'h1a, d);
      n = n + 1;
    end while (d[15] !== 1'b1 && n < 100);
    check(16'(d[15]), 16'h0001);
    repeat (70) @(posedge core_clk_in);
    rd(5'h1b, d);
    // freeze with an 8-unit restart: one load falls due while frozen
    wr(5'h1a, 16'h000f);
    variance_term_in <= 16'h0001;
    repeat (140) @(posedge core_clk_in);
    rd(5'h1b, d);
    check(d, 16'hffe0);
    rd(5'h1b, d);
    check(d, 16'h001f);
    rd(5'h1a, d);
    check(d, 16'h0007);
    $display("test variance done");
    foreach (codes[i]) begin
      wr(5'h1a, 16'(codes[i] * 2 + 1));
      t0 = cycles;
      rd(5'h1b, d);
      rd(5'h1b, d);
      n = 0;
      do begin
        rd(5'h1a, d);
        n = n + 1;
      end while (d[15] !== 1'b1 && n < 200);
      n = cycles - t0 - 32 * (codes[i] + 1);
      check(16'(n >= -2 && n <= 6), 16'h0001);
    end
    $display("test timer done");
    wrap_up();
  end
endmodule
